//--- arp_match_regs.vh
/*
 * register map, field positions, reset values and frame constants of the
 * arp frame rule matcher.
 * assumes inclusion by its bare name from the matcher's design files.
 */
// Contract
// - arp criteria apply only with arp entry type
// - opcode class any, arp only, rarp only
// - fourth class hits only unknown opcodes
// - request/reply selection any, request, reply
// - sender filter off ignores sender address
// - host mode compares sender address exactly
// - network mode compares sender address under mask
// - target filter behaves like sender filter
// - sha match one needs sha equal source mac
// - sha match zero needs sha differ source mac
// - tha match on rarp, zero differs, one equals
// - length match one needs lengths six, four
// - hardware type match one needs value one
// - protocol type match one needs 0x800
// - every three-state setting has don't-care value
// - hit counter advances once per hit
`ifndef ARP_MATCH_REGS_VH
`define ARP_MATCH_REGS_VH

// byte addresses
`define REG_CTRL_ADDR        8'h00
`define REG_SND_ADDR_ADDR    8'h04
`define REG_SND_MASK_ADDR    8'h08
`define REG_TGT_ADDR_ADDR    8'h0c
`define REG_TGT_MASK_ADDR    8'h10
`define REG_HIT_COUNT_ADDR   8'h14
`define REG_STATUS_ADDR      8'h18

// control field positions (lsb of each 2-bit field)
`define CTRL_TYPE_ARP_BIT    0
`define CTRL_OPCLASS_LSB     1
`define CTRL_REQREP_LSB      3
`define CTRL_SND_MODE_LSB    5
`define CTRL_TGT_MODE_LSB    7
`define CTRL_SHA_LSB         9
`define CTRL_THA_LSB         11
`define CTRL_LEN_LSB         13
`define CTRL_HWT_LSB         15
`define CTRL_PRT_LSB         17
`define CTRL_WIDTH           19
// three-state selections start as don't-care, opcode class rarp, request/reply reply, address modes network; entry type not arp
`define CTRL_RESET           19'h55554

// opcode class settings
`define OPCLASS_ANY          2'h0
`define OPCLASS_ARP          2'h1
`define OPCLASS_RARP         2'h2
`define OPCLASS_OTHER        2'h3
// request/reply settings (3 behaves as any)
`define REQREP_ANY           2'h0
`define REQREP_REQUEST       2'h1
`define REQREP_REPLY         2'h2
// address filter modes (3 behaves as any)
`define ADDR_MODE_ANY        2'h0
`define ADDR_MODE_HOST       2'h1
`define ADDR_MODE_NETWORK    2'h2
// three-state settings (3 behaves as any)
`define TRI_ZERO             2'h0
`define TRI_ONE              2'h1
`define TRI_ANY              2'h2

// frame field values
`define OP_ARP_REQUEST       16'h0001
`define OP_ARP_REPLY         16'h0002
`define OP_RARP_REQUEST      16'h0003
`define OP_RARP_REPLY        16'h0004
`define HW_LEN_ETHERNET      8'h06
`define PROTO_LEN_IPV4       8'h04
`define HW_TYPE_ETHERNET     16'h0001
`define PROTO_TYPE_IP        16'h0800

// axi answers
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

//--- tri_match.v
/*
 * three-state field test: zero, one or don't-care against a condition.
 * assumes the setting is held stable by the caller; purely combinational.
 */
`include "arp_match_regs.vh"

module tri_match (
    input  wire [1:0] setting,
    input  wire       applies,
    input  wire       cond,
    output reg        ok
);
    always @* begin
        case (setting)
            `TRI_ZERO: ok = applies & ~cond;
            `TRI_ONE:  ok = applies & cond;
            default:   ok = 1'b1;
        endcase
    end
endmodule // tri_match

//--- proto_addr_filter.v
/*
 * protocol address filter: any, exact host or masked network compare.
 * assumes address and mask come from registers on the same clock.
 */
`include "arp_match_regs.vh"

module proto_addr_filter (
    input  wire [1:0]  mode,
    input  wire [31:0] cfg_addr,
    input  wire [31:0] cfg_mask,
    input  wire [31:0] frame_addr,
    output reg         ok
);
    always @* begin
        case (mode)
            `ADDR_MODE_HOST:    ok = (frame_addr == cfg_addr);
            `ADDR_MODE_NETWORK: ok = ((frame_addr & cfg_mask) == (cfg_addr & cfg_mask));
            default:            ok = 1'b1;
        endcase
    end
endmodule // proto_addr_filter

//--- arp_frame_rule_matcher.v
/*
 * arp part of one access control entry: per-frame match decision,
 * hit counter and the axi4-lite register file that configures it.
 * assumes the ingress parser presents all header fields together with a
 * one-cycle frame_valid on aclk; the axi master is on aclk as well.
 */
`include "arp_match_regs.vh"

module arp_frame_rule_matcher #(
    parameter CNT_W = 32
) (
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // frame fields from the ingress parser
    input  wire        frame_valid,
    input  wire [15:0] frame_opcode,
    input  wire [47:0] frame_source_mac,
    input  wire [47:0] frame_sender_hw,
    input  wire [47:0] frame_target_hw,
    input  wire [31:0] sender_proto_addr,
    input  wire [31:0] frame_target_proto,
    input  wire [7:0]  frame_hw_len,
    input  wire [7:0]  frame_proto_len,
    input  wire [15:0] hardware_type_field,
    input  wire [15:0] frame_proto_type,
    // decision, one cycle after frame_valid
    output reg         match_valid,
    output reg         match_hit
);

    function [31:0] apply_strb;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  strb;
        integer i;
        begin
            apply_strb = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    apply_strb[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    function addr_known;
        input [7:0] a;
        begin
            addr_known = (a == `REG_CTRL_ADDR) || (a == `REG_SND_ADDR_ADDR) ||
                         (a == `REG_SND_MASK_ADDR) || (a == `REG_TGT_ADDR_ADDR) ||
                         (a == `REG_TGT_MASK_ADDR) || (a == `REG_HIT_COUNT_ADDR) ||
                         (a == `REG_STATUS_ADDR);
        end
    endfunction

    // configuration registers
    reg  [`CTRL_WIDTH-1:0] ctrl_r;
    reg  [31:0]            snd_addr_r;
    reg  [31:0]            snd_mask_r;
    reg  [31:0]            tgt_addr_r;
    reg  [31:0]            tgt_mask_r;
    reg  [CNT_W-1:0]       hit_count_r;
    reg  [CNT_W-1:0]       hit_count_nxt;

    // write channel state
    reg                    aw_full_r;
    reg  [7:0]             aw_addr_r;
    reg                    w_full_r;
    reg  [31:0]            w_data_r;
    reg  [3:0]             w_strb_r;

    wire [1:0] opclass  = ctrl_r[`CTRL_OPCLASS_LSB +: 2];
    wire [1:0] reqrep   = ctrl_r[`CTRL_REQREP_LSB +: 2];
    wire [1:0] snd_mode = ctrl_r[`CTRL_SND_MODE_LSB +: 2];
    wire [1:0] tgt_mode = ctrl_r[`CTRL_TGT_MODE_LSB +: 2];
    wire       type_arp = ctrl_r[`CTRL_TYPE_ARP_BIT];

    // opcode decode
    wire op_arp  = (frame_opcode == `OP_ARP_REQUEST) || (frame_opcode == `OP_ARP_REPLY);
    wire op_rarp = (frame_opcode == `OP_RARP_REQUEST) || (frame_opcode == `OP_RARP_REPLY);
    wire op_req  = (frame_opcode == `OP_ARP_REQUEST) || (frame_opcode == `OP_RARP_REQUEST);
    wire op_rep  = (frame_opcode == `OP_ARP_REPLY) || (frame_opcode == `OP_RARP_REPLY);

    reg  opclass_ok;
    reg  reqrep_ok;
    wire snd_ok;
    wire tgt_ok;
    wire sha_ok;
    wire tha_ok;
    wire len_ok;
    wire hwt_ok;
    wire prt_ok;
    wire arp_all_ok;
    wire entry_hit;

    always @* begin
        case (opclass)
            `OPCLASS_ARP:   opclass_ok = op_arp;
            `OPCLASS_RARP:  opclass_ok = op_rarp;
            `OPCLASS_OTHER: opclass_ok = ~op_arp & ~op_rarp;
            default:        opclass_ok = 1'b1;
        endcase
    end

    always @* begin
        case (reqrep)
            `REQREP_REQUEST: reqrep_ok = op_req;
            `REQREP_REPLY:   reqrep_ok = op_rep;
            default:         reqrep_ok = 1'b1;
        endcase
    end

    proto_addr_filter u_snd_filter (
        .mode       (snd_mode),
        .cfg_addr   (snd_addr_r),
        .cfg_mask   (snd_mask_r),
        .frame_addr (sender_proto_addr),
        .ok         (snd_ok)
    );

    proto_addr_filter u_tgt_filter (
        .mode       (tgt_mode),
        .cfg_addr   (tgt_addr_r),
        .cfg_mask   (tgt_mask_r),
        .frame_addr (frame_target_proto),
        .ok         (tgt_ok)
    );

    tri_match u_sha (
        .setting (ctrl_r[`CTRL_SHA_LSB +: 2]),
        .applies (op_arp),
        .cond    (frame_sender_hw == frame_source_mac),
        .ok      (sha_ok)
    );

    tri_match u_tha (
        .setting (ctrl_r[`CTRL_THA_LSB +: 2]),
        .applies (op_rarp),
        .cond    (frame_target_hw == frame_source_mac),
        .ok      (tha_ok)
    );

    tri_match u_len (
        .setting (ctrl_r[`CTRL_LEN_LSB +: 2]),
        .applies (1'b1),
        .cond    ((frame_hw_len == `HW_LEN_ETHERNET) && (frame_proto_len == `PROTO_LEN_IPV4)),
        .ok      (len_ok)
    );

    tri_match u_hwt (
        .setting (ctrl_r[`CTRL_HWT_LSB +: 2]),
        .applies (1'b1),
        .cond    (hardware_type_field == `HW_TYPE_ETHERNET),
        .ok      (hwt_ok)
    );

    tri_match u_prt (
        .setting (ctrl_r[`CTRL_PRT_LSB +: 2]),
        .applies (1'b1),
        .cond    (frame_proto_type == `PROTO_TYPE_IP),
        .ok      (prt_ok)
    );

    assign arp_all_ok = opclass_ok & reqrep_ok & snd_ok & tgt_ok &
                        sha_ok & tha_ok & len_ok & hwt_ok & prt_ok;
    assign entry_hit  = ~type_arp | arp_all_ok;

    // decision register
    always @(posedge aclk) begin
        if (!aresetn) begin
            match_valid <= 1'b0;
            match_hit   <= 1'b0;
        end else begin
            match_valid <= frame_valid;
            match_hit   <= frame_valid & entry_hit;
        end
    end

    // write channel: address and data taken in either order
    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire aw_full  = aw_full_r | aw_take;
    wire w_full   = w_full_r | w_take;
    wire [7:0]  wr_addr = aw_full_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_full_r ? w_data_r : s_axi_wdata;
    wire [3:0]  wr_strb = w_full_r ? w_strb_r : s_axi_wstrb;
    wire wr_do    = aw_full & w_full & ~s_axi_bvalid;
    wire cnt_clr  = wr_do & (wr_addr == `REG_HIT_COUNT_ADDR);
    // ctrl is narrower than the bus: upper written bits are dropped
    wire [31:0] ctrl_wr = apply_strb({{(32-`CTRL_WIDTH){1'b0}}, ctrl_r}, wr_data, wr_strb);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r     <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_full_r      <= 1'b0;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_full_r     <= 1'b0;
                w_full_r      <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= addr_known(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                aw_full_r     <= aw_full;
                w_full_r      <= w_full;
                s_axi_awready <= ~aw_full & ~s_axi_bvalid;
                s_axi_wready  <= ~w_full & ~s_axi_bvalid;
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid  <= 1'b0;
                    s_axi_awready <= 1'b1;
                    s_axi_wready  <= 1'b1;
                end
            end
        end
    end

    // configuration writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r     <= `CTRL_RESET;
            snd_addr_r <= 32'h0000_0000;
            snd_mask_r <= 32'h0000_0000;
            tgt_addr_r <= 32'h0000_0000;
            tgt_mask_r <= 32'h0000_0000;
        end else if (wr_do) begin
            case (wr_addr)
                `REG_CTRL_ADDR: begin
                    ctrl_r <= ctrl_wr[`CTRL_WIDTH-1:0];
                end
                `REG_SND_ADDR_ADDR: snd_addr_r <= apply_strb(snd_addr_r, wr_data, wr_strb);
                `REG_SND_MASK_ADDR: snd_mask_r <= apply_strb(snd_mask_r, wr_data, wr_strb);
                `REG_TGT_ADDR_ADDR: tgt_addr_r <= apply_strb(tgt_addr_r, wr_data, wr_strb);
                `REG_TGT_MASK_ADDR: tgt_mask_r <= apply_strb(tgt_mask_r, wr_data, wr_strb);
                default: begin
                end
            endcase
        end
    end

    // hit counter: a hit in the clearing cycle still counts
    always @* begin
        hit_count_nxt = cnt_clr ? {CNT_W{1'b0}} : hit_count_r;
        if (frame_valid && entry_hit) begin
            hit_count_nxt = hit_count_nxt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            hit_count_r <= {CNT_W{1'b0}};
        end else begin
            hit_count_r <= hit_count_nxt;
        end
    end

    // read channel
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            `REG_CTRL_ADDR:      rd_mux = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_r};
            `REG_SND_ADDR_ADDR:  rd_mux = snd_addr_r;
            `REG_SND_MASK_ADDR:  rd_mux = snd_mask_r;
            `REG_TGT_ADDR_ADDR:  rd_mux = tgt_addr_r;
            `REG_TGT_MASK_ADDR:  rd_mux = tgt_mask_r;
            `REG_HIT_COUNT_ADDR: rd_mux = hit_count_r[31:0];
            `REG_STATUS_ADDR:    rd_mux = {30'h0000_0000, match_hit, match_valid};
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= addr_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule // arp_frame_rule_matcher

//--- arp_match_checker_props.sv
/* checker for the arp matcher: decision timing and register bus answers.
   assumes it is bound to the matcher top module and sees only its ports. */
`include "arp_match_regs.vh"
module arp_match_checker #(
    parameter CNT_W = 32
) (
    input wire        aclk,
    input wire        aresetn,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        frame_valid,
    input wire        match_valid,
    input wire        match_hit
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_decision_delay: assert property ($past(aresetn) |-> match_valid == $past(frame_valid))
        else $error("decision not one cycle after frame");
    a_hit_qualified: assert property (match_hit |-> match_valid)
        else $error("hit without decision");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during answer");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read not answered");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
        |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_bad_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && s_axi_awaddr > 8'h18 |=> s_axi_bresp == `RESP_SLVERR)
        else $error("unmapped write not refused");
endmodule // arp_match_checker

bind arp_frame_rule_matcher arp_match_checker #(.CNT_W(CNT_W)) chk_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .frame_valid(frame_valid), .match_valid(match_valid),
    .match_hit(match_hit));

//--- arp_frame_source.sv
/* ingress parser model: presents one arp header per call for one cycle.
   assumes callers enter send just after a rising edge of aclk. */
module arp_frame_source (
    input  wire        aclk,
    output reg         frame_valid = 1'b0,
    output reg  [15:0] opcode = 16'h0,
    output reg  [47:0] src_mac = 48'h0,
    output reg  [47:0] sha = 48'h0,
    output reg  [47:0] tha = 48'h0,
    output reg  [31:0] spa = 32'h0,
    output reg  [31:0] tpa = 32'h0,
    output reg  [7:0]  hlen = 8'h0,
    output reg  [7:0]  plen = 8'h0,
    output reg  [15:0] htype = 16'h0,
    output reg  [15:0] ptype = 16'h0
);
    localparam [47:0] MAC = 48'h02a1b2c3d4e5;
    task send(input [15:0] op, input s_eq, input t_eq, input [31:0] sa, input [31:0] ta,
              input [7:0] hl, input [15:0] ht, input [15:0] pt);
        begin
            @(posedge aclk);
            frame_valid <= 1'b1;
            {opcode, src_mac, spa, tpa, hlen, plen, htype, ptype} <=
                {op, MAC, sa, ta, hl, 8'h04, ht, pt};
            sha <= s_eq ? MAC : MAC ^ 48'h1;
            tha <= t_eq ? MAC : MAC ^ 48'h100;
            @(posedge aclk);
            frame_valid <= 1'b0;
            // fields outside a frame carry no stale header
            {opcode, src_mac, sha, tha, spa, tpa, hlen, plen, htype, ptype} <=
                ~{opcode, src_mac, sha, tha, spa, tpa, hlen, plen, htype, ptype};
        end
    endtask
endmodule // arp_frame_source

//--- test_arp_frame_rule_matcher.sv
/* self-checking bench of the arp matcher: bus tasks, frame scenarios, verdict.
   assumes the frame source model and the checker are compiled before it. */
`include "arp_match_regs.vh"
module test_arp_frame_rule_matcher;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [31:0] SA = 32'hc0a80105;
    localparam [31:0] TA = 32'hc0a801fe;
    // arp entry with every selection don't-care
    localparam [31:0] BASE = 32'h00055401;
    reg         aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    reg         arvalid = 0, rready = 0, g_sha = 1, g_tha = 1;
    reg  [7:0]  awaddr = 0, araddr = 0, g_hl = 8'h06;
    reg  [31:0] wdata = 0;
    reg  [15:0] g_hwt = 16'h1, g_pt = 16'h0800;
    wire        awready, wready, bvalid, arready, rvalid, fv, match_valid, match_hit;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata, spa, tpa;
    wire [15:0] op_w, hwt, pt;
    wire [47:0] src_mac, sha, tha;
    wire [7:0]  hl, pl;
    integer     num_errors = 0, tests_run = 0, c, k, op;
    arp_frame_source src (.aclk(aclk), .frame_valid(fv), .opcode(op_w), .src_mac(src_mac),
        .sha(sha), .tha(tha), .spa(spa), .tpa(tpa), .hlen(hl), .plen(pl), .htype(hwt),
        .ptype(pt));
    arp_frame_rule_matcher dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .frame_valid(fv), .frame_opcode(op_w), .frame_source_mac(src_mac),
        .frame_sender_hw(sha), .frame_target_hw(tha), .sender_proto_addr(spa),
        .frame_target_proto(tpa), .frame_hw_len(hl), .frame_proto_len(pl),
        .hardware_type_field(hwt), .frame_proto_type(pt), .match_valid(match_valid),
        .match_hit(match_hit));
    initial begin
        forever #2.5 aclk = ~aclk;
    end
    task chk(input [31:0] g, input [31:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        reg done;
        begin
            done = 0;
            @(posedge aclk);
            {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
            while (!done) begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid) begin
                    done = 1;
                    bready <= 1'b0;
                    chk(bresp, er);
                end
            end
        end
    endtask
    task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
        reg done;
        begin
            done = 0;
            @(posedge aclk);
            {araddr, arvalid, rready} <= {a, 2'b11};
            while (!done) begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
                if (rvalid) begin
                    done = 1;
                    rready <= 1'b0;
                    chk(rdata, ed);
                    chk(rresp, er);
                end
            end
        end
    endtask
    task ctl(input integer lsb, input [1:0] v);
        wr(`REG_CTRL_ADDR, (BASE & ~(32'h3 << lsb)) | ({30'h0, v} << lsb), 2'h0);
    endtask
    task fr(input [15:0] o, input [31:0] sa, input [31:0] ta, input e);
        begin
            src.send(o, g_sha, g_tha, sa, ta, g_hl, g_hwt, g_pt);
            #1;
            chk(match_valid, 1'b1);
            chk(match_hit, e);
        end
    endtask
    task t_regs;
        begin
            rd(`REG_CTRL_ADDR, 32'h00055554, 2'h0);
            rd(`REG_HIT_COUNT_ADDR, 32'h0, 2'h0);
            rd(8'h40, 32'h0, `RESP_SLVERR);
            wr(8'h40, 32'hffffffff, `RESP_SLVERR);
            wr(`REG_SND_ADDR_ADDR, SA, 2'h0);
            wr(`REG_SND_MASK_ADDR, 32'hffffff00, 2'h0);
            wr(`REG_TGT_ADDR_ADDR, TA, 2'h0);
            wr(`REG_TGT_MASK_ADDR, 32'hffff0000, 2'h0);
            rd(`REG_SND_MASK_ADDR, 32'hffffff00, 2'h0);
            wr(`REG_CTRL_ADDR, 32'h55552, 2'h0);
            fr(16'h3, SA, TA, 1'b1);
            wr(`REG_CTRL_ADDR, 32'h55553, 2'h0);
            fr(16'h3, SA, TA, 1'b0);
            $display("registers and entry type done");
        end
    endtask
    task t_ops;
        begin
            for (c = 0; c < 4; c = c + 1) begin
                ctl(`CTRL_OPCLASS_LSB, c[1:0]);
                for (op = 0; op < 6; op = op + 1)
                    fr(op[15:0], SA, TA, c == 0 || (c == 1 && op > 0 && op < 3) ||
                        (c == 2 && op > 2 && op < 5) || (c == 3 && (op == 0 || op == 5)));
            end
            for (c = 0; c < 3; c = c + 1) begin
                ctl(`CTRL_REQREP_LSB, c[1:0]);
                for (op = 1; op < 5; op = op + 1)
                    fr(op[15:0], SA, TA, c == 0 || (c == 1) == op[0]);
            end
            $display("opcode selections done");
        end
    endtask
    task t_addr;
        begin
            ctl(`CTRL_SND_MODE_LSB, `ADDR_MODE_ANY);
            fr(16'h1, ~SA, ~TA, 1'b1);
            ctl(`CTRL_SND_MODE_LSB, `ADDR_MODE_HOST);
            fr(16'h1, SA, TA, 1'b1);
            fr(16'h1, SA ^ 32'h1, TA, 1'b0);
            ctl(`CTRL_SND_MODE_LSB, `ADDR_MODE_NETWORK);
            fr(16'h1, SA ^ 32'h80, TA, 1'b1);
            fr(16'h1, SA ^ 32'h100, TA, 1'b0);
            ctl(`CTRL_TGT_MODE_LSB, `ADDR_MODE_HOST);
            fr(16'h1, SA, TA ^ 32'h2, 1'b0);
            ctl(`CTRL_TGT_MODE_LSB, `ADDR_MODE_NETWORK);
            fr(16'h1, SA, TA ^ 32'hff00, 1'b1);
            fr(16'h1, SA, TA ^ 32'h10000, 1'b0);
            $display("address filters done");
        end
    endtask
    task t_fields;
        begin
            for (c = 0; c < 2; c = c + 1) for (k = 0; k < 2; k = k + 1) begin
                ctl(`CTRL_SHA_LSB, c[1:0]);
                g_sha = k;
                fr(16'h1, SA, TA, c == k);
                ctl(`CTRL_THA_LSB, c[1:0]);
                g_tha = k;
                fr(16'h4, SA, TA, c == k);
            end
            {g_sha, g_tha} = 2'b11;
            for (k = 0; k < 3; k = k + 1) for (c = 0; c < 3; c = c + 1) begin
                ctl(13 + 2 * k, c[1:0]);
                for (op = 0; op < 2; op = op + 1) begin
                    g_hl = (k == 0 && op == 1) ? 8'h08 : 8'h06;
                    g_hwt = (k == 1 && op == 1) ? 16'h6 : 16'h1;
                    g_pt = (k == 2 && op == 1) ? 16'h86dd : 16'h0800;
                    fr(16'h1, SA, TA, c == 2 || (c == 1) != op);
                end
            end
            $display("header field matches done");
        end
    endtask
    task t_and_count;
        begin
            wr(`REG_CTRL_ADDR, BASE | 32'h2c, 2'h0);
            fr(16'h3, SA, TA, 1'b1);
            fr(16'h2, SA, TA, 1'b0);
            fr(16'h3, SA ^ 32'h1, TA, 1'b0);
            wr(`REG_HIT_COUNT_ADDR, 32'h0, 2'h0);
            for (k = 0; k < 3; k = k + 1)
                fr(16'h3, SA, TA, 1'b1);
            fr(16'h2, SA, TA, 1'b0);
            wr(`REG_STATUS_ADDR, 32'h0, 2'h0);
            rd(`REG_HIT_COUNT_ADDR, 32'h3, 2'h0);
            wr(`REG_HIT_COUNT_ADDR, 32'h0, 2'h0);
            rd(`REG_HIT_COUNT_ADDR, 32'h0, 2'h0);
            $display("combined match and counter done");
        end
    endtask
    task stop_test;
        begin
            $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        #50000;
        num_errors = num_errors + 1;
        stop_test;
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_ops;
        t_addr;
        t_fields;
        t_and_count;
        stop_test;
    end
endmodule // test_arp_frame_rule_matcher
